// ### tsx_pkg.sv
package tsx_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_INSTR    = 12'h004;
  localparam logic [11:0] OFS_OPERAND  = 12'h008;
  localparam logic [11:0] OFS_ACC      = 12'h00C;
  localparam logic [11:0] OFS_FLAGS    = 12'h010;
  localparam logic [11:0] OFS_TIMER    = 12'h014;
  localparam logic [11:0] OFS_TPAGE    = 12'h018;
  localparam logic [11:0] OFS_TPTR     = 12'h01C;
  localparam logic [11:0] OFS_WAKE     = 12'h020;
  localparam logic [11:0] OFS_PC       = 12'h024;
  localparam logic [11:0] OFS_TBL_ADDR = 12'h028;
  localparam logic [11:0] OFS_TBL_DATA = 12'h02C;
  localparam logic [11:0] OFS_BANK_LO  = 12'h040;
  localparam logic [11:0] OFS_BANK_HI  = 12'h07C;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int unsigned CTRL_LONG_BIT = 0;
  localparam int unsigned FLG_F         = 0;
  localparam int unsigned FLG_CY        = 1;
  localparam int unsigned FLG_SBY       = 2;
  localparam int unsigned FLG_STOP      = 3;
  localparam int unsigned FLG_BUSY      = 4;
  localparam int unsigned FLG_ILL       = 5;
  localparam int unsigned FLG_TMR       = 6;
  localparam int unsigned TSEL_BIT      = 5;
  localparam int unsigned WAKE_TMR_BIT  = 3;

  // ------------------------------------------------------------
  // Opcodes and masks
  // ------------------------------------------------------------
  localparam logic [9:0] OP_NOP       = 10'h000;
  localparam logic [9:0] OP_T_ACC     = 10'h09F;
  localparam logic [9:0] OP_T_ACC_MSK = 10'h3DF;
  localparam logic [9:0] OP_T_IMM     = 10'h0DF;
  localparam logic [9:0] OP_T_TBL     = 10'h0FF;
  localparam logic [9:0] OP_HALT      = 10'h051;
  localparam logic [9:0] OP_STATUS_TEST_INSTR_IMM  = 10'h071;
  localparam logic [9:0] OP_STATUS_TEST_INSTR_REG  = 10'h060;
  localparam logic [9:0] OP_STATUS_TEST_INSTR_MSK  = 10'h3F0;
  localparam logic [9:0] OP_CARRY_IF_ALL_ONES_INSTR      = 10'h353;
  localparam logic [5:0] OPND_HI_ZERO = 6'h00;
  localparam logic [3:0] ACC_ALL_ONES = 4'hF;

  // ------------------------------------------------------------
  // Timer prescale terminal counts, oscillator periods minus one
  // ------------------------------------------------------------
  localparam logic [6:0] PRESC_SHORT = 7'h3F;
  localparam logic [6:0] PRESC_LONG  = 7'h7F;

  localparam logic [9:0] PC_STEP1 = 10'h001;
  localparam logic [9:0] PC_STEP2 = 10'h002;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_TABLE,
    ST_STANDBY
  } tsx_state_t;

endpackage

// ### tsx_tbl_mem.sv
`timescale 1ns/1ps
`default_nettype none
module tsx_tbl_mem (
  input  wire logic       clk_i,
  input  wire logic       we_i,
  input  wire logic [9:0] waddr_i,
  input  wire logic [9:0] wdata_i,
  input  wire logic [9:0] raddr_i,
  output logic      [9:0] rdata_o
);
  // ------------------------------------------------------------
  // Table storage, registered read
  // ------------------------------------------------------------
  logic [9:0] mem [0:1023];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // No reset: contents are software loaded before use
  always_ff @(posedge clk_i) begin
    rdata_o <= mem[raddr_i];
  end
endmodule // tsx_tbl_mem
`default_nettype wire

// ### tsx_interval_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tsx_interval_timer import tsx_pkg::*; (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       load_i,
  input  wire logic [9:0] setting_i,
  input  wire logic       long_i,
  input  wire logic       run_i,
  output logic            status_o
);
  // ------------------------------------------------------------
  // Prescaler and interval counter
  // ------------------------------------------------------------
  logic [6:0] presc_reg;
  logic [9:0] cnt_reg;
  logic       tick;

  assign tick = run_i & (presc_reg == (long_i ? PRESC_LONG : PRESC_SHORT));

  always_ff @(posedge clk_i) begin
    if (rst_i | load_i | tick) begin
      presc_reg <= '0;
    end else if (run_i) begin
      presc_reg <= presc_reg + 7'h01;
    end
  end

  // Interval is (setting + 1) prescaled periods
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else if (load_i) begin
      cnt_reg <= setting_i;
    end else if (tick) begin
      cnt_reg <= (cnt_reg == '0) ? setting_i : cnt_reg - 10'h001;
    end
  end

  // Expiry beats a load in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_o <= 1'b0;
    end else if (tick && cnt_reg == '0) begin
      status_o <= 1'b1;
    end else if (load_i) begin
      status_o <= 1'b0;
    end
  end
endmodule // tsx_interval_timer
`default_nettype wire

// ### tsx_exec_top.sv
// Operation
// - Accumulator-to-timer load writes bits 9..6 or 5..2, chosen by one opcode bit.
// - Upper-nibble load clears timer bit 1, lower-nibble load clears timer bit 0.
// - Immediate load takes t1, t9..t6, t0, t5..t2 from the second word, top down.
// - Immediate load replaces all ten timer bits in one instruction cycle.
// - Timer interval is (setting + 1) times 64 or 128 oscillator periods.
// - Table load puts a ten-bit table word into the timer register.
// - Table address takes its top two bits from the page control, rest from the pointer pair.
// - Standby halts execution and enters halt or stop.
// - Standby second word holds a four-bit field choosing the release conditions.
// - Standby second word has its upper six bits zero.
// - Register status test sets the status flag when any masked status is active.
// - Immediate status test does the same with a mask from the second word.
// - Either status test clears the status flag when nothing matches.
// - Carry-if-all-ones sets carry for accumulator 1111, clears it otherwise.
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tsx_exec_top import tsx_pkg::*; (
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire logic        SENSE0_I,
  input  wire logic        SENSE1_I,
  input  wire logic [3:0]  KEY_IN_I,
  input  wire logic [7:0]  KEY_BIDIR_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic             STANDBY_O,
  output logic             STOP_MODE_O,
  output logic             STATUS_FLAG_O,
  output logic             CARRY_O,
  output logic      [9:0]  TIMER_O,
  output logic      [9:0]  PC_O
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic in_bank(input logic [11:0] a);
    in_bank = (a >= OFS_BANK_LO) && (a <= OFS_BANK_HI);
  endfunction

  // Masked status match shared by both status tests
  function automatic logic status_hit(input logic [3:0] mask,
                                      input logic [3:0] cond);
    status_hit = |(mask & cond);
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  tsx_state_t state_reg;
  logic        long_reg;
  logic [9:0]  instr_reg;
  logic [9:0]  operand_reg;
  logic [3:0]  acc_reg;
  logic [1:0]  page_reg;
  logic [7:0]  ptr_reg;
  logic [3:0]  wake_reg;
  logic [9:0]  tbl_addr_reg;
  logic        ill_reg;
  logic [3:0]  bank_reg [0:15];
  logic [9:0]  tbl_rdata;
  logic        tmr_status;
  logic [9:0]  timer_next;
  logic        timer_load;

  // ------------------------------------------------------------
  // APB slave, one wait state
  // ------------------------------------------------------------
  logic        apb_acc;
  logic        apb_wr;
  logic        mapped;
  logic [31:0] rd_data;

  assign apb_acc = PSEL_I & PENABLE_I;
  assign apb_wr  = apb_acc & PREADY_O & PWRITE_I;

  always_comb begin
    rd_data = '0;
    mapped  = 1'b1;
    if (PADDR_I[1:0] != 2'b00) begin
      mapped = 1'b0;
    end else if (in_bank(PADDR_I)) begin
      rd_data[3:0] = bank_reg[PADDR_I[5:2]];
    end else begin
      case (PADDR_I)
        OFS_CTRL:     rd_data[CTRL_LONG_BIT] = long_reg;
        OFS_INSTR:    rd_data[9:0] = instr_reg;
        OFS_OPERAND:  rd_data[9:0] = operand_reg;
        OFS_ACC:      rd_data[3:0] = acc_reg;
        OFS_FLAGS: begin
          rd_data[FLG_F]    = STATUS_FLAG_O;
          rd_data[FLG_CY]   = CARRY_O;
          rd_data[FLG_SBY]  = STANDBY_O;
          rd_data[FLG_STOP] = STOP_MODE_O;
          rd_data[FLG_BUSY] = (state_reg == ST_TABLE);
          rd_data[FLG_ILL]  = ill_reg;
          rd_data[FLG_TMR]  = tmr_status;
        end
        OFS_TIMER:    rd_data[9:0] = TIMER_O;
        OFS_TPAGE:    rd_data[1:0] = page_reg;
        OFS_TPTR:     rd_data[7:0] = ptr_reg;
        OFS_WAKE:     rd_data[3:0] = wake_reg;
        OFS_PC:       rd_data[9:0] = PC_O;
        OFS_TBL_ADDR: rd_data[9:0] = tbl_addr_reg;
        OFS_TBL_DATA: rd_data      = '0;
        default:      mapped       = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= '0;
    end else begin
      PREADY_O <= apb_acc & ~PREADY_O;
      if (apb_acc & ~PREADY_O) begin
        PSLVERR_O <= ~mapped;
        PRDATA_O  <= PWRITE_I ? 32'h0000_0000 : rd_data;
      end else begin
        PSLVERR_O <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Software-written configuration
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      long_reg     <= 1'b0;
      operand_reg  <= '0;
      page_reg     <= '0;
      ptr_reg      <= '0;
      tbl_addr_reg <= '0;
    end else if (apb_wr) begin
      case (PADDR_I)
        OFS_CTRL:     long_reg     <= PWDATA_I[CTRL_LONG_BIT];
        OFS_OPERAND:  operand_reg  <= PWDATA_I[9:0];
        OFS_TPAGE:    page_reg     <= PWDATA_I[1:0];
        OFS_TPTR:     ptr_reg      <= PWDATA_I[7:0];
        OFS_TBL_ADDR: tbl_addr_reg <= PWDATA_I[9:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (apb_wr && mapped && in_bank(PADDR_I)) begin
      bank_reg[PADDR_I[5:2]] <= PWDATA_I[3:0];
    end
  end

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  logic       launch;
  logic [9:0] op;
  logic       op_t_acc;
  logic       op_t_imm;
  logic       op_t_tbl;
  logic       op_halt;
  logic       op_status_test_instr_i;
  logic       op_status_test_instr_r;
  logic       op_carry_if_all_ones_instr;
  logic       op_nop;
  logic       opnd_ok;
  logic       op_legal;
  logic [3:0] cond_status_test_instr;
  logic [3:0] cond_wake;

  // Instruction writes while busy or in standby are dropped
  assign launch = apb_wr && (PADDR_I == OFS_INSTR) && (state_reg == ST_RUN);
  assign op     = PWDATA_I[9:0];

  assign op_t_acc  = (op & OP_T_ACC_MSK) == OP_T_ACC;
  assign op_t_imm  = op == OP_T_IMM;
  assign op_t_tbl  = op == OP_T_TBL;
  assign op_halt   = op == OP_HALT;
  assign op_status_test_instr_i = op == OP_STATUS_TEST_INSTR_IMM;
  assign op_status_test_instr_r = (op & OP_STATUS_TEST_INSTR_MSK) == OP_STATUS_TEST_INSTR_REG;
  assign op_carry_if_all_ones_instr   = op == OP_CARRY_IF_ALL_ONES_INSTR;
  assign op_nop    = op == OP_NOP;
  assign opnd_ok   = operand_reg[9:4] == OPND_HI_ZERO;
  assign op_legal  = op_t_acc | op_t_imm | op_t_tbl | op_carry_if_all_ones_instr | op_nop | op_status_test_instr_r
                   | ((op_halt | op_status_test_instr_i) & opnd_ok);

  assign cond_status_test_instr = {tmr_status, |{KEY_IN_I, KEY_BIDIR_I}, SENSE1_I, SENSE0_I};
  assign cond_wake = {tmr_status, SENSE0_I | SENSE1_I, |KEY_BIDIR_I, |KEY_IN_I};

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_reg   <= ST_RUN;
      wake_reg    <= '0;
      STANDBY_O   <= 1'b0;
      STOP_MODE_O <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_RUN: begin
          if (launch && op_t_tbl) begin
            state_reg <= ST_TABLE;
          end else if (launch && op_halt && opnd_ok) begin
            state_reg   <= ST_STANDBY;
            STANDBY_O   <= 1'b1;
            wake_reg    <= operand_reg[3:0];
            // Timer frozen unless it is a release source
            STOP_MODE_O <= ~operand_reg[WAKE_TMR_BIT];
          end
        end
        ST_TABLE: state_reg <= ST_RUN;
        ST_STANDBY: begin
          // Empty release field leaves only reset as the way out
          if (status_hit(wake_reg, cond_wake)) begin
            state_reg   <= ST_RUN;
            STANDBY_O   <= 1'b0;
            STOP_MODE_O <= 1'b0;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Timer register
  // ------------------------------------------------------------
  always_comb begin
    timer_next = TIMER_O;
    timer_load = 1'b0;
    if (state_reg == ST_TABLE) begin
      timer_next = tbl_rdata;
      timer_load = 1'b1;
    end else if (launch && op_t_acc) begin
      timer_load = 1'b1;
      if (op[TSEL_BIT]) begin
        timer_next = {acc_reg, TIMER_O[5:2], 1'b0, TIMER_O[0]};
      end else begin
        timer_next = {TIMER_O[9:6], acc_reg, TIMER_O[1], 1'b0};
      end
    end else if (launch && op_t_imm) begin
      timer_load = 1'b1;
      timer_next = {operand_reg[8:5], operand_reg[3:0],
                    operand_reg[9], operand_reg[4]};
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      TIMER_O <= '0;
    end else if (timer_load) begin
      TIMER_O <= timer_next;
    end
  end

  tsx_interval_timer u_timer (
    .clk_i     (CLK_I),
    .rst_i     (RST_I),
    .load_i    (timer_load),
    .setting_i (timer_next),
    .long_i    (long_reg),
    .run_i     (~STOP_MODE_O),
    .status_o  (tmr_status)
  );

  // ------------------------------------------------------------
  // Table memory, one extra cycle for the registered read
  // ------------------------------------------------------------
  tsx_tbl_mem u_tbl (
    .clk_i   (CLK_I),
    .we_i    (apb_wr && (PADDR_I == OFS_TBL_DATA)),
    .waddr_i (tbl_addr_reg),
    .wdata_i (PWDATA_I[9:0]),
    .raddr_i ({page_reg, ptr_reg}),
    .rdata_o (tbl_rdata)
  );

  // ------------------------------------------------------------
  // Flags, accumulator, program counter
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      STATUS_FLAG_O <= 1'b0;
    end else if (launch && op_status_test_instr_r) begin
      STATUS_FLAG_O <= status_hit(bank_reg[op[3:0]], cond_status_test_instr);
    end else if (launch && op_status_test_instr_i && opnd_ok) begin
      STATUS_FLAG_O <= status_hit(operand_reg[3:0], cond_status_test_instr);
    end else if (apb_wr && PADDR_I == OFS_FLAGS) begin
      STATUS_FLAG_O <= PWDATA_I[FLG_F];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      CARRY_O <= 1'b0;
    end else if (launch && op_carry_if_all_ones_instr) begin
      CARRY_O <= acc_reg == ACC_ALL_ONES;
    end else if (apb_wr && PADDR_I == OFS_FLAGS) begin
      CARRY_O <= PWDATA_I[FLG_CY];
    end
  end

  // Sticky bad-opcode flag; a new fault beats the clear
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ill_reg <= 1'b0;
    end else if (launch && !op_legal) begin
      ill_reg <= 1'b1;
    end else if (apb_wr && PADDR_I == OFS_FLAGS && PWDATA_I[FLG_ILL]) begin
      ill_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      acc_reg <= '0;
    end else if (apb_wr && PADDR_I == OFS_ACC) begin
      acc_reg <= PWDATA_I[3:0];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      instr_reg <= '0;
    end else if (launch) begin
      instr_reg <= op;
    end
  end

  // Two-word instructions step past their second word
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      PC_O <= '0;
    end else if (launch && op_legal) begin
      if (op_t_imm || op_halt || op_status_test_instr_i) begin
        PC_O <= PC_O + PC_STEP2;
      end else begin
        PC_O <= PC_O + PC_STEP1;
      end
    end
  end

endmodule // tsx_exec_top
`default_nettype wire

// ### tsx_exec_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module tsx_exec_props import tsx_pkg::*; (
  input wire logic        CLK_I,
  input wire logic        RST_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic        SENSE0_I,
  input wire logic        SENSE1_I,
  input wire logic [3:0]  KEY_IN_I,
  input wire logic [7:0]  KEY_BIDIR_I,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        STANDBY_O,
  input wire logic        STOP_MODE_O,
  input wire logic        STATUS_FLAG_O,
  input wire logic        CARRY_O,
  input wire logic [9:0]  TIMER_O,
  input wire logic [9:0]  PC_O
);
  // ----------------------------------------
  // Shadows of operand and accumulator
  // ----------------------------------------
  logic       wr_done;
  logic       exec;
  logic [9:0] op;
  logic [3:0] cond;
  logic [9:0] opnd_reg;
  logic [3:0] acc_reg;
  assign wr_done = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O && !PSLVERR_O;
  assign exec    = wr_done && PADDR_I == OFS_INSTR && !STANDBY_O;
  assign op      = PWDATA_I[9:0];
  // Timer status is not at the ports, so mask bit 3 stays out
  assign cond    = {1'b0, |{KEY_IN_I, KEY_BIDIR_I}, SENSE1_I, SENSE0_I};
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      opnd_reg <= 10'h000;
    end else if (wr_done && PADDR_I == OFS_OPERAND) begin
      opnd_reg <= PWDATA_I[9:0];
    end
  end
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      acc_reg <= 4'h0;
    end else if (wr_done && PADDR_I == OFS_ACC) begin
      acc_reg <= PWDATA_I[3:0];
    end
  end
  default clocking dc @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  a_nop_pc_step: assert property (
    exec && op == OP_NOP |=> PC_O == $past(PC_O) + PC_STEP1 && $stable(TIMER_O))
    else $error("nop changed state");
  a_acc_low_load: assert property (
    exec && op == OP_T_ACC |=>
    TIMER_O == {$past(TIMER_O[9:6]), $past(acc_reg), $past(TIMER_O[1]), 1'b0})
    else $error("low nibble load wrong");
  a_acc_high_load: assert property (
    exec && op == 10'h0BF |=>
    TIMER_O == {$past(acc_reg), $past(TIMER_O[5:2]), 1'b0, $past(TIMER_O[0])})
    else $error("high nibble load wrong");
  a_imm_timer_load: assert property (
    exec && op == OP_T_IMM |=> TIMER_O == {$past(opnd_reg[8:5]), $past(opnd_reg[3:0]),
                                           $past(opnd_reg[9]), $past(opnd_reg[4])})
    else $error("immediate timer load wrong");
  a_carry_all_ones: assert property (
    exec && op == OP_CARRY_IF_ALL_ONES_INSTR |=> CARRY_O == ($past(acc_reg) == ACC_ALL_ONES))
    else $error("carry wrong");
  a_status_test_instr_imm_flag: assert property (
    exec && op == OP_STATUS_TEST_INSTR_IMM && opnd_reg[9:3] == 7'h00 |=>
    STATUS_FLAG_O == |($past(opnd_reg[3:0]) & $past(cond)))
    else $error("status flag wrong");
  a_halt_enters_sby: assert property (
    exec && op == OP_HALT && opnd_reg[9:4] == OPND_HI_ZERO |=>
    STANDBY_O && STOP_MODE_O == !$past(opnd_reg[WAKE_TMR_BIT]))
    else $error("standby entry wrong");
  a_halt_bad_opnd: assert property (
    exec && op == OP_HALT && opnd_reg[9:4] != OPND_HI_ZERO |=> !STANDBY_O && $stable(PC_O))
    else $error("bad standby operand accepted");
  a_sby_no_exec: assert property (
    STANDBY_O && wr_done && PADDR_I == OFS_INSTR |=> $stable(PC_O) && $stable(TIMER_O))
    else $error("executed in standby");
  c_table_load: cover property (exec && op == OP_T_TBL);
  c_halt: cover property (exec && op == OP_HALT);
  c_release: cover property ($fell(STANDBY_O));
endmodule // tsx_exec_props

bind tsx_exec_top tsx_exec_props u_props (
  .CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .SENSE0_I(SENSE0_I),
  .SENSE1_I(SENSE1_I), .KEY_IN_I(KEY_IN_I), .KEY_BIDIR_I(KEY_BIDIR_I),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .STANDBY_O(STANDBY_O),
  .STOP_MODE_O(STOP_MODE_O), .STATUS_FLAG_O(STATUS_FLAG_O), .CARRY_O(CARRY_O),
  .TIMER_O(TIMER_O), .PC_O(PC_O)
);
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import tsx_pkg::*; ;
  localparam int LIMIT = 20000;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, s0 = 1'b0, s1 = 1'b0;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0000_0000;
  logic [3:0]  kin = 4'h0;
  logic [7:0]  kbd = 8'h00;
  logic [31:0] q;
  logic        err;
  logic [9:0]  pc0;
  logic [9:0]  tm0;
  logic [9:0]  imm [3] = '{10'h2AA, 10'h155, 10'h210};
  logic [3:0]  accv [4] = '{4'hE, 4'hF, 4'h7, 4'h0};
  wire  [31:0] prdata;
  wire         pready, pslverr, sby, stp, flag, cy;
  wire  [9:0]  tmr, pc;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          t0;

  tsx_exec_top u_dut (
    .CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(padr), .PWDATA_I(pwd), .SENSE0_I(s0), .SENSE1_I(s1), .KEY_IN_I(kin),
    .KEY_BIDIR_I(kbd), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .STANDBY_O(sby), .STOP_MODE_O(stp), .STATUS_FLAG_O(flag), .CARRY_O(cy),
    .TIMER_O(tmr), .PC_O(pc)
  );

  always #5 clk = ~clk;
  // Hang guard, far beyond the planned run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      stop_test();
    end
  end

  // ----------------------------------------
  // Bus cycles and compares
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr  <= w;
    padr <= a;
    pwd  <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q    = prdata;
    err  = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  // Results land at the completion edge, so look at the next falling edge
  task automatic ex(input logic [9:0] o, input logic [9:0] d);
    apb(1'b1, OFS_OPERAND, {22'h00_0000, d});
    apb(1'b1, OFS_INSTR, {22'h00_0000, o});
    @(negedge clk);
  endtask
  task automatic chkv(input logic [9:0] g, input logic [9:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e, input string m);
    chkv({9'h000, g}, {9'h000, e}, m);
  endtask
  // Setting 3 gives 4 * p clocks; a poll costs four, hence the slack
  task automatic tmr_wait(input int p);
    t0 = cyc;
    q  = 32'h0000_0000;
    while (q[FLG_TMR] !== 1'b1) apb(1'b0, OFS_FLAGS, 32'h0000_0000);
    chkb((cyc - t0) > 4 * p && (cyc - t0) <= 4 * p + 4, 1'b1, "interval");
  endtask
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, OFS_FLAGS, 32'h0000_0000);
    chkv(q[9:0], 10'h000, "flags reset");
    chkv(pc, 10'h000, "pc reset");
    apb(1'b0, 12'h030, 32'h0000_0000);
    chkb(err, 1'b1, "unmapped");
    $display("Test reset done");
    ex(OP_T_IMM, 10'h3FF);
    chkv(tmr, 10'h3FF, "imm ones");
    apb(1'b1, OFS_ACC, 32'h0000_0005);
    ex(OP_T_ACC, 10'h000);
    chkv(tmr, 10'h3D6, "low nibble");
    apb(1'b1, OFS_ACC, 32'h0000_000A);
    ex(10'h0BF, 10'h000);
    chkv(tmr, 10'h294, "high nibble");
    apb(1'b0, OFS_TIMER, 32'h0000_0000);
    chkv(q[9:0], 10'h294, "timer read");
    foreach (imm[i]) begin
      pc0 = pc;
      ex(OP_T_IMM, imm[i]);
      chkv(tmr, {imm[i][8:5], imm[i][3:0], imm[i][9], imm[i][4]}, "imm");
      chkv(pc, pc0 + PC_STEP2, "imm pc");
    end
    tmr_wait(64);
    ex(OP_STATUS_TEST_INSTR_IMM, 10'h008);
    chkb(flag, 1'b1, "timer mask");
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    ex(OP_T_IMM, 10'h210);
    tmr_wait(128);
    $display("Test timer done");
    apb(1'b1, OFS_TBL_ADDR, 32'h0000_0234);
    apb(1'b1, OFS_TBL_DATA, 32'h0000_01C5);
    apb(1'b1, OFS_TBL_ADDR, 32'h0000_0034);
    apb(1'b1, OFS_TBL_DATA, 32'h0000_00A3);
    apb(1'b1, OFS_TPTR, 32'h0000_0034);
    for (int pg = 2; pg >= 0; pg -= 2) begin
      apb(1'b1, OFS_TPAGE, 32'(pg));
      ex(OP_T_TBL, 10'h000);
      @(negedge clk);
      chkv(tmr, (pg == 2) ? 10'h1C5 : 10'h0A3, "table");
    end
    $display("Test table done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      s0  <= (i == 0);
      s1  <= (i == 1);
      kin <= (i == 2) ? 4'h8 : 4'h0;
      kbd <= (i == 3) ? 8'h40 : 8'h00;
      for (int m = 0; m < 3; m++) begin
        ex(OP_STATUS_TEST_INSTR_IMM, 10'(1 << m));
        chkb(flag, m == ((i < 2) ? i : 2), "status imm");
      end
    end
    @(posedge clk);
    s1  <= 1'b1;
    kbd <= 8'h00;
    apb(1'b1, OFS_BANK_LO + 12'h014, 32'h0000_0002);
    apb(1'b1, OFS_BANK_LO + 12'h018, 32'h0000_0001);
    ex(OP_STATUS_TEST_INSTR_REG | 10'h005, 10'h000);
    chkb(flag, 1'b1, "status reg hit");
    ex(OP_STATUS_TEST_INSTR_REG | 10'h006, 10'h000);
    chkb(flag, 1'b0, "status reg miss");
    $display("Test status done");
    foreach (accv[i]) begin
      apb(1'b1, OFS_ACC, {28'h000_0000, accv[i]});
      ex(OP_CARRY_IF_ALL_ONES_INSTR, 10'h000);
      chkb(cy, accv[i] == 4'hF, "carry");
    end
    pc0 = pc;
    tm0 = tmr;
    ex(OP_NOP, 10'h000);
    chkv(pc, pc0 + PC_STEP1, "nop pc");
    chkv(tmr, tm0, "nop timer");
    $display("Test carry nop done");
    @(posedge clk);
    s1 <= 1'b0;
    pc0 = pc;
    ex(OP_HALT, 10'h014);
    chkb(sby, 1'b0, "bad operand");
    chkv(pc, pc0, "bad operand pc");
    apb(1'b0, OFS_FLAGS, 32'h0000_0000);
    chkb(q[FLG_ILL], 1'b1, "ill flag");
    apb(1'b1, OFS_FLAGS, 32'h0000_0023);
    apb(1'b0, OFS_FLAGS, 32'h0000_0000);
    chkv(q[9:0], 10'h003, "flags write");
    ex(OP_HALT, 10'h004);
    chkb(sby, 1'b1, "standby");
    chkb(stp, 1'b1, "stop mode");
    pc0 = pc;
    ex(OP_NOP, 10'h000);
    chkv(pc, pc0, "halted pc");
    apb(1'b0, OFS_WAKE, 32'h0000_0000);
    chkv(q[9:0], 10'h004, "wake field");
    @(posedge clk);
    s0 <= 1'b1;
    repeat (3) @(negedge clk);
    chkb(sby, 1'b0, "sense release");
    ex(OP_HALT, 10'h009);
    chkb(stp, 1'b0, "halt mode");
    @(posedge clk);
    s0  <= 1'b0;
    kin <= 4'h1;
    repeat (3) @(negedge clk);
    chkb(sby, 1'b0, "key release");
    $display("Test standby done");
    stop_test();
  end
endmodule // testbench
`default_nettype wire
